/* rtl/ccb_pkg.sv */
// shared constants for the cpu configuration and bank addressing block
// Functional notes
// - any reset loads program counter 000h and all registers take defaults
// - taken interrupt pushes program counter to stack then fetches from 004h
// - config word is 16 bits, changed by nonvolatile programming and reloaded to 0200h by any reset
// - bit 15 set blocks external readout of program memory
// - bits 13-12: 0X off, 10 on in run modes only, 11 always on
// - bits 11-8 pick one of sixteen rising low-voltage reset thresholds
// - bit 7 makes shared pin an external reset, else plain port bit
// - bit 5 selects fast oscillator divide by 1 or by 2
// - bit 4 selects continuous or one-in-sixteen power-on detector duty
// - four banks of 128 locations, low part registers, upper part static ram
// - direct access bank comes from status bits 6:5
// - frequently used registers alias across banks to one physical register
// - indirect access port has no storage, redirects through pointer register
// - indirect read with pointer zero returns 00h
// - indirect write with pointer zero changes nothing
// - indirect address is status bit 7 above the 8-bit pointer
// - protection bit clears by programming only after user program area erased, and on any reset
package ccb_pkg;
  localparam logic [11:0] CCB_RESET_VECTOR = 12'h000;
  localparam logic [11:0] CCB_INT_VECTOR   = 12'h004;
  localparam int          CCB_CFG_W        = 16;
  localparam int          CCB_PROTECT_BIT  = 15;
  localparam int          CCB_WDT_HI       = 13;
  localparam int          CCB_WDT_LO       = 12;
  localparam int          CCB_LVR_HI       = 11;
  localparam int          CCB_LVR_LO       = 8;
  localparam int          CCB_XRST_BIT     = 7;
  localparam int          CCB_PSC_BIT      = 5;
  localparam int          CCB_POR_BIT      = 4;
  localparam int          CCB_ST_IRP       = 7;
  localparam int          CCB_ST_RP1       = 6;
  localparam int          CCB_ST_RP0       = 5;
  localparam logic [15:0] CCB_CFG_RESET    = 16'h0200;
  localparam logic [15:0] CCB_CFG_ERASED   = 16'h0000;
  localparam logic [6:0]  CCB_INDIRECT_ACCESS_PORT_OFS     = 7'h00;
  localparam logic [6:0]  CCB_STATUS_OFS   = 7'h03;
  localparam logic [6:0]  CCB_PTR_OFS      = 7'h04;
  localparam logic [6:0]  CCB_COMMON_LO    = 7'h70;
  localparam logic [7:0]  CCB_STATUS_RESET = 8'h00;
  localparam logic [7:0]  CCB_PTR_RESET    = 8'h00;
  localparam logic [3:0]  CCB_POR_PERIOD   = 4'hf;
  localparam int          CCB_ADDR_W       = 9;
  localparam int          CCB_STACK_D      = 8;

  typedef enum logic [1:0] {
    CCB_WDT_RUN  = 2'b00,
    CCB_WDT_IDLE = 2'b01,
    CCB_WDT_STOP = 2'b11,
    CCB_WDT_SLOW = 2'b10
  } ccb_mode_t;

  // direct address: bank bits over instruction field
  function automatic logic [8:0] ccb_direct(input logic [1:0] bank, input logic [6:0] f);
    return {bank, f};
  endfunction : ccb_direct

  // folds the common area and the aliased core registers onto bank 0
  function automatic logic [8:0] ccb_fold(input logic [8:0] a);
    if (a[6:0] >= CCB_COMMON_LO || a[6:0] == CCB_STATUS_OFS || a[6:0] == CCB_PTR_OFS)
      return {2'b00, a[6:0]};
    return a;
  endfunction : ccb_fold
endpackage : ccb_pkg

/* rtl/ccb_data_ram.sv */
// data memory plane storage, four banks of 128 bytes, registered read
`timescale 1ns/100ps
`default_nettype none
module ccb_data_ram (
  // clock
  input  wire logic       sys_clk,
  // write port
  input  wire logic       wrEn,
  input  wire logic [8:0] wrAddr,
  input  wire logic [7:0] wrData,
  // read port
  input  wire logic [8:0] rdAddr,
  output logic      [7:0] rdData
);
  logic [7:0] mem [0:511];

  // no reset on storage; ram content is undefined after power up
  always_ff @(posedge sys_clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule : ccb_data_ram
`default_nettype wire

/* rtl/ccb_pc_stack.sv */
// hardware return stack for the program counter
`timescale 1ns/100ps
`default_nettype none
module ccb_pc_stack (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // push and pop
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic [11:0] pushData,
  output logic      [11:0] topData
);
  import ccb_pkg::*;
  typedef struct packed {
    logic [CCB_STACK_D-1:0][11:0] ent;
    logic [2:0]                   ptr;
    logic [11:0]                  top;
  } ccb_stk_t;
  ccb_stk_t s_q, s_d;

  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.ent[s_q.ptr] = pushData;
      s_d.ptr          = s_q.ptr + 3'h1;
    end
    else if (pop)
    begin
      s_d.ptr = s_q.ptr - 3'h1;
    end
    s_d.top = s_d.ent[s_d.ptr - 3'h1];
  end

  // circular: overflow silently overwrites the oldest entry
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  assign topData = s_q.top;
endmodule : ccb_pc_stack
`default_nettype wire

/* rtl/ccb_core.sv */
// cpu configuration decode, vectors and data memory bank addressing
`timescale 1ns/100ps
`default_nettype none
module ccb_core (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    arst_n,
  // nonvolatile programming of the configuration word and external program memory readout
  input  wire logic                    cfgProgWr,
  input  wire logic [ccb_pkg::CCB_CFG_W-1:0] cfgProgData,
  input  wire logic                    userAreaErased,
  input  wire logic                    extReadReq,
  input  wire logic [11:0]             extReadAddr,
  input  wire logic [15:0]             progMemData,
  output logic      [15:0]             extReadData,
  output logic                         extReadBlocked,
  // decoded configuration
  output logic      [15:0]             config_word_high,
  output logic                         watchdogResetEnable,
  output logic      [3:0]            brownout_threshold_select,
  output logic                         ext_pin_reset_enable,
  output logic                         port_a_bit7_is_io,
  output logic                         fast_osc_prescale,
  output logic                         porDetectEnable,
  input  wire logic [1:0]              runMode,
  // program counter sequencing
  input  wire logic                    pcStep,
  input  wire logic                    pcLoad,
  input  wire logic [11:0]             pcLoadAddr,
  input  wire logic                    intTake,
  input  wire logic                    retPop,
  output logic      [11:0]             progCounter,
  // data memory access
  input  wire logic                    memRd,
  input  wire logic                    memWr,
  input  wire logic [6:0]              fileField,
  input  wire logic [7:0]              memWrData,
  output logic      [7:0]              memRdData,
  output logic      [8:0]              effAddr,
  output logic      [7:0]              statusReg,
  output logic      [7:0]              pointer_register
);
  import ccb_pkg::*;

  typedef struct packed {
    logic [15:0] cfg;
    logic [11:0] pc;
    logic [7:0]  status;
    logic [7:0]  ptr;
    logic [3:0]  porCnt;
    logic        zeroRd;
    logic        sfrRd;
    logic [7:0]  sfrData;
    logic [15:0] xData;
    logic        xBlk;
  } ccb_st_t;
  ccb_st_t r_q, r_d;

  logic [1:0]  bank;
  logic        isIndirect;
  logic        ptrZero;
  logic [8:0]  rawAddr;
  logic [8:0]  physAddr;
  logic        ramWr;
  logic        isStatus;
  logic        isPtr;
  logic [7:0]  ramRdData;
  logic [11:0] stackTop;

  assign bank       = {r_q.status[CCB_ST_RP1], r_q.status[CCB_ST_RP0]};
  assign isIndirect = (fileField == CCB_INDIRECT_ACCESS_PORT_OFS);
  assign ptrZero    = (r_q.ptr == 8'h00);
  assign rawAddr    = isIndirect ? {r_q.status[CCB_ST_IRP], r_q.ptr} : ccb_direct(bank, fileField);
  assign physAddr   = ccb_fold(rawAddr);
  assign isStatus   = (physAddr[6:0] == CCB_STATUS_OFS) && !(isIndirect && ptrZero);
  assign isPtr      = (physAddr[6:0] == CCB_PTR_OFS) && !(isIndirect && ptrZero);
  // pointer zero write is a no-op; core registers do not live in ram
  assign ramWr      = memWr && !(isIndirect && ptrZero) && !isStatus && !isPtr;

  always_comb
  begin
    r_d        = r_q;
    r_d.zeroRd = memRd && isIndirect && ptrZero;
    r_d.sfrRd  = memRd && (isStatus || isPtr);
    r_d.sfrData = isStatus ? r_q.status : r_q.ptr;
    // only programming and reset alter the word; programming clears protect only when erased
    if (cfgProgWr)
    begin
      if (!cfgProgData[CCB_PROTECT_BIT] && r_q.cfg[CCB_PROTECT_BIT] && !userAreaErased)
        r_d.cfg = {1'b1, cfgProgData[14:0]};
      else
        r_d.cfg = cfgProgData;
    end
    if (intTake)
      r_d.pc = CCB_INT_VECTOR;
    else if (retPop)
      r_d.pc = stackTop;
    else if (pcLoad)
      r_d.pc = pcLoadAddr;
    else if (pcStep)
      r_d.pc = r_q.pc + 12'h001;
    if (memWr && isStatus)
      r_d.status = memWrData;
    if (memWr && isPtr)
      r_d.ptr = memWrData;
    r_d.porCnt = r_q.porCnt + 4'h1;
    r_d.xBlk   = extReadReq && r_q.cfg[CCB_PROTECT_BIT];
    if (extReadReq)
      r_d.xData = r_q.cfg[CCB_PROTECT_BIT] ? 16'h0000 : progMemData;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r_q        <= '0;
      r_q.cfg    <= CCB_CFG_RESET;
      r_q.pc     <= CCB_RESET_VECTOR;
      r_q.status <= CCB_STATUS_RESET;
      r_q.ptr    <= CCB_PTR_RESET;
    end
    else
      r_q <= r_d;
  end

  ccb_pc_stack u_stack (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .push     (intTake),
    .pop      (retPop && !intTake),
    .pushData (r_q.pc),
    .topData  (stackTop)
  );

  ccb_data_ram u_ram (
    .sys_clk (sys_clk),
    .wrEn    (ramWr),
    .wrAddr  (physAddr),
    .wrData  (memWrData),
    .rdAddr  (physAddr),
    .rdData  (ramRdData)
  );

  // decode; bits 14, 6 and 3-0 deliberately unused
  always_comb
  begin
    case (r_q.cfg[CCB_WDT_HI:CCB_WDT_LO])
      2'b10:   watchdogResetEnable = (runMode == CCB_WDT_RUN) || (runMode == CCB_WDT_SLOW);
      2'b11:   watchdogResetEnable = 1'b1;
      default: watchdogResetEnable = 1'b0;
    endcase
  end
  assign config_word_high          = r_q.cfg;
  assign brownout_threshold_select = r_q.cfg[CCB_LVR_HI:CCB_LVR_LO];
  assign ext_pin_reset_enable      = r_q.cfg[CCB_XRST_BIT];
  assign port_a_bit7_is_io         = ~r_q.cfg[CCB_XRST_BIT];
  assign fast_osc_prescale         = r_q.cfg[CCB_PSC_BIT];
  // duty mode: detector on one count in sixteen
  assign porDetectEnable = !r_q.cfg[CCB_POR_BIT] || (r_q.porCnt == CCB_POR_PERIOD);
  assign progCounter      = r_q.pc;
  assign statusReg        = r_q.status;
  assign pointer_register = r_q.ptr;
  assign effAddr          = physAddr;
  assign extReadData      = r_q.xData;
  assign extReadBlocked   = r_q.xBlk;
  assign memRdData = r_q.zeroRd ? 8'h00 : (r_q.sfrRd ? r_q.sfrData : ramRdData);

  property p_intvec;
    @(posedge sys_clk) disable iff (!arst_n) intTake |=> progCounter == 12'h004;
  endproperty
  a_intvec: assert property (p_intvec) else $error("no jump to interrupt vector");
  property p_zero_rd;
    @(posedge sys_clk) disable iff (!arst_n) (memRd && isIndirect && ptrZero) |=> memRdData == 8'h00;
  endproperty
  a_zero_rd: assert property (p_zero_rd) else $error("pointer zero read not zero");
  property p_zero_wr;
    @(posedge sys_clk) disable iff (!arst_n) (isIndirect && ptrZero) |-> !ramWr;
  endproperty
  a_zero_wr: assert property (p_zero_wr) else $error("pointer zero write hit ram");
  property p_cfg_stable;
    @(posedge sys_clk) disable iff (!arst_n) !$past(cfgProgWr) |-> $stable(config_word_high);
  endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("config changed without programming");
  property p_protect;
    @(posedge sys_clk) disable iff (!arst_n)
      (extReadReq && config_word_high[15]) |=> extReadBlocked && extReadData == 16'h0000;
  endproperty
  a_protect: assert property (p_protect) else $error("protected readout leaked");
  property p_wdt;
    @(posedge sys_clk) disable iff (!arst_n) config_word_high[13] == 1'b0 |-> !watchdogResetEnable;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog enabled while off");
  property p_ind_addr;
    @(posedge sys_clk) disable iff (!arst_n)
      (isIndirect && pointer_register[6:0] >= 7'h05 && pointer_register[6:0] < 7'h70)
        |-> effAddr == {statusReg[7], pointer_register};
  endproperty
  a_ind_addr: assert property (p_ind_addr) else $error("indirect address wrong");
  property p_dir_addr;
    @(posedge sys_clk) disable iff (!arst_n)
      (!isIndirect && fileField >= 7'h05 && fileField < 7'h70) |-> effAddr == {statusReg[6:5], fileField};
  endproperty
  a_dir_addr: assert property (p_dir_addr) else $error("direct address wrong");
  property p_prot_keep;
    @(posedge sys_clk) disable iff (!arst_n)
      (cfgProgWr && config_word_high[15] && !userAreaErased) |=> config_word_high[15];
  endproperty
  a_prot_keep: assert property (p_prot_keep) else $error("protect cleared without erase");
  property p_por_duty;
    @(posedge sys_clk) disable iff (!arst_n)
      (!cfgProgWr && config_word_high[4] && porDetectEnable) |=> !porDetectEnable;
  endproperty
  a_por_duty: assert property (p_por_duty) else $error("detector duty wrong");

  c_int:  cover property (@(posedge sys_clk) intTake ##[1:4] retPop);
  c_zero: cover property (@(posedge sys_clk) memRd && isIndirect && ptrZero);
  c_bank3: cover property (@(posedge sys_clk) memWr && bank == 2'b11);
  c_prot: cover property (@(posedge sys_clk) extReadReq && config_word_high[15]);
endmodule : ccb_core
`default_nettype wire

/* verification/ccb_core_bench.sv */
// self-checking bench for the configuration decode, vectors and bank addressing
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    cmpCount++; \
    if ((got) !== (exp)) \
    begin \
      failCount++; \
      $display("[FAIL] %0t %s", $time, msg); \
    end \
  end
module ccb_core_bench;
  import ccb_pkg::*;
  logic        sys_clk, arst_n, cfgProgWr, userAreaErased, extReadReq;
  logic [15:0] cfgProgData, progMemData, extReadData, config_word_high;
  logic [11:0] extReadAddr, pcLoadAddr, progCounter;
  logic        extReadBlocked, watchdogResetEnable, ext_pin_reset_enable;
  logic        port_a_bit7_is_io, fast_osc_prescale, porDetectEnable;
  logic [3:0]  brownout_threshold_select;
  logic [1:0]  runMode;
  logic        pcStep, pcLoad, intTake, retPop, memRd, memWr;
  logic [6:0]  fileField;
  logic [7:0]  memWrData, memRdData, statusReg, pointer_register, rdVal;
  logic [8:0]  effAddr;
  int          failCount, cmpCount, hits;
  logic [15:0] words [5] = '{16'h3fb0, 16'h2000, 16'h1a5f, 16'h005f, 16'h8c40};

  ccb_core dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .cfgProgWr(cfgProgWr), .cfgProgData(cfgProgData),
    .userAreaErased(userAreaErased), .extReadReq(extReadReq), .extReadAddr(extReadAddr),
    .progMemData(progMemData), .extReadData(extReadData), .extReadBlocked(extReadBlocked),
    .config_word_high(config_word_high), .watchdogResetEnable(watchdogResetEnable),
    .brownout_threshold_select(brownout_threshold_select),
    .ext_pin_reset_enable(ext_pin_reset_enable), .port_a_bit7_is_io(port_a_bit7_is_io),
    .fast_osc_prescale(fast_osc_prescale), .porDetectEnable(porDetectEnable),
    .runMode(runMode), .pcStep(pcStep), .pcLoad(pcLoad), .pcLoadAddr(pcLoadAddr),
    .intTake(intTake), .retPop(retPop), .progCounter(progCounter), .memRd(memRd),
    .memWr(memWr), .fileField(fileField), .memWrData(memWrData), .memRdData(memRdData),
    .effAddr(effAddr), .statusReg(statusReg), .pointer_register(pointer_register)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic closeOut();
    if (failCount == 0 && cmpCount > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : closeOut

  // one data memory access; effective address checked while the strobe stands
  task automatic mem(input logic wr, input logic [6:0] f, input logic [7:0] d,
                     input logic [8:0] ea);
    @(posedge sys_clk);
    memWr     <= wr;
    memRd     <= !wr;
    fileField <= f;
    memWrData <= d;
    #1;
    `CHK(effAddr, ea, "effective address")
    @(posedge sys_clk);
    memWr <= 1'b0;
    memRd <= 1'b0;
    #1;
    rdVal = memRdData;
  endtask : mem

  task automatic prog(input logic [15:0] w, input logic erased);
    @(posedge sys_clk);
    cfgProgWr      <= 1'b1;
    cfgProgData    <= w;
    userAreaErased <= erased;
    @(posedge sys_clk);
    cfgProgWr <= 1'b0;
    #1;
  endtask : prog

  task automatic pcOp(input int op, input logic [11:0] a, input logic [11:0] exp);
    @(posedge sys_clk);
    {intTake, retPop, pcLoad, pcStep} <= 4'(1 << op);
    pcLoadAddr <= a;
    @(posedge sys_clk);
    {intTake, retPop, pcLoad, pcStep} <= 4'h0;
    #1;
    `CHK(progCounter, exp, "program counter")
  endtask : pcOp

  task automatic chkCfg(input logic [15:0] w);
    `CHK(config_word_high, w, "config word")
    `CHK(brownout_threshold_select, w[11:8], "threshold code")
    `CHK(ext_pin_reset_enable, w[7], "pin reset enable")
    `CHK(port_a_bit7_is_io, !w[7], "pin as port bit")
    `CHK(fast_osc_prescale, w[5], "prescaler")
    for (int rm = 0; rm < 4; rm++)
    begin
      @(posedge sys_clk);
      runMode <= 2'(rm);
      #1;
      `CHK(watchdogResetEnable, w[13] && (w[12] || !rm[0]), "watchdog policy")
    end
    hits = 0;
    for (int i = 0; i < 32; i++)
    begin
      @(posedge sys_clk);
      #1;
      if (porDetectEnable === 1'b1)
        hits++;
    end
    `CHK(hits, (w[4] ? 2 : 32), "detector duty")
    @(posedge sys_clk);
    extReadReq <= 1'b1;
    @(posedge sys_clk);
    extReadReq <= 1'b0;
    #1;
    `CHK(extReadData, (w[15] ? 16'h0000 : progMemData), "readout data")
    `CHK(extReadBlocked, w[15], "readout blocked")
  endtask : chkCfg

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failCount++;
    closeOut();
  end

  initial
  begin
    {arst_n, cfgProgWr, userAreaErased, extReadReq, pcStep, pcLoad} = '0;
    {intTake, retPop, memRd, memWr} = '0;
    {cfgProgData, extReadAddr, pcLoadAddr, fileField, memWrData, runMode} = '0;
    progMemData = 16'hbeef;
    failCount   = 0;
    cmpCount    = 0;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    #1;
    `CHK(progCounter, CCB_RESET_VECTOR, "reset vector")
    `CHK({statusReg, pointer_register}, 16'h0000, "register defaults")
    chkCfg(CCB_CFG_RESET);
    foreach (words[i])
    begin
      prog(words[i], 1'b1);
      chkCfg(words[i]);
    end
    // protection stays until the user area reports erased
    prog(16'h0000, 1'b0);
    `CHK(config_word_high[15], 1'b1, "protect kept")
    prog(16'h0000, 1'b1);
    `CHK(config_word_high, 16'h0000, "protect cleared")
    pcOp(0, 12'h000, 12'h001);
    pcOp(1, 12'h123, 12'h123);
    pcOp(3, 12'h000, CCB_INT_VECTOR);
    pcOp(2, 12'h000, 12'h123);
    for (int b = 0; b < 4; b++)
    begin
      mem(1, CCB_STATUS_OFS, 8'(b << 5), {2'b00, CCB_STATUS_OFS});
      mem(1, 7'h20, 8'h10 + 8'(b), {2'(b), 7'h20});
    end
    for (int b = 0; b < 4; b++)
    begin
      mem(1, CCB_STATUS_OFS, 8'(b << 5), {2'b00, CCB_STATUS_OFS});
      mem(0, 7'h20, 8'h00, {2'(b), 7'h20});
      `CHK(rdVal, 8'h10 + 8'(b), "bank storage")
    end
    mem(1, CCB_PTR_OFS, 8'h33, {2'b00, CCB_PTR_OFS});
    mem(1, 7'h70, 8'hc3, 9'h070);
    mem(1, CCB_STATUS_OFS, 8'h00, {2'b00, CCB_STATUS_OFS});
    mem(0, CCB_PTR_OFS, 8'h00, {2'b00, CCB_PTR_OFS});
    `CHK(rdVal, 8'h33, "pointer alias")
    mem(0, 7'h70, 8'h00, 9'h070);
    `CHK(rdVal, 8'hc3, "common area")
    // indirect write into bank 2 space, then read it back directly
    mem(1, CCB_PTR_OFS, 8'h2f, 9'h004);
    mem(1, CCB_STATUS_OFS, 8'h80, 9'h003);
    mem(1, CCB_INDIRECT_ACCESS_PORT_OFS, 8'h5a, 9'h12f);
    mem(1, CCB_STATUS_OFS, 8'hc0, 9'h003);
    mem(0, 7'h2f, 8'h00, 9'h12f);
    `CHK(rdVal, 8'h5a, "indirect write")
    mem(0, CCB_INDIRECT_ACCESS_PORT_OFS, 8'h00, 9'h12f);
    `CHK(rdVal, 8'h5a, "indirect read")
    mem(1, CCB_PTR_OFS, 8'h00, 9'h004);
    mem(0, CCB_INDIRECT_ACCESS_PORT_OFS, 8'h00, 9'h100);
    `CHK(rdVal, 8'h00, "null pointer read")
    mem(1, CCB_INDIRECT_ACCESS_PORT_OFS, 8'h77, 9'h100);
    `CHK({statusReg[7:5], pointer_register}, 11'h600, "null pointer write")
    mem(0, CCB_INDIRECT_ACCESS_PORT_OFS, 8'h00, 9'h100);
    `CHK(rdVal, 8'h00, "null pointer after write")
    // reset in mid-run brings pc, config and status back
    @(posedge sys_clk);
    arst_n <= 1'b0;
    #1;
    `CHK(progCounter, CCB_RESET_VECTOR, "mid-run reset pc")
    `CHK(config_word_high, CCB_CFG_RESET, "mid-run reset config")
    `CHK(statusReg, CCB_STATUS_RESET, "mid-run reset status")
    @(posedge sys_clk);
    arst_n <= 1'b1;
    pcOp(0, 12'h000, 12'h001);
    closeOut();
  end
endmodule : ccb_core_bench
`default_nettype wire
